// File: tb/csp_ram_model.sv
// Byte-wide stack RAM model with one-cycle reads.
module csp_ram_model (
  input wire logic ref_clk,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWrEn,
  input wire logic memRdEn,
  output logic [7:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [65536];
  initial memRdData = 8'h00;
  // ----------------------------------------------------------------
  // Storage and read port
  // ----------------------------------------------------------------
  // Outside a read the data toggles, so a mistimed capture shows.
  always @(posedge ref_clk) begin
    if (memWrEn) begin
      mem[memAddr] <= memWrData;
    end
    if (memRdEn) begin
      memRdData <= mem[memAddr];
    end else begin
      memRdData <= ~memRdData;
    end
  end
endmodule

// File: tb/csp_stack_unit_monitor.sv
// Concurrent checks on the stack unit's ports.
module csp_stack_unit_monitor (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdValid,
  input wire csp_pkg::csp_op_t cmdOp,
  input wire logic cmdReady,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] idxXIn,
  input wire logic [7:0] accAIn,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWrEn,
  input wire logic memRdEn,
  input wire logic [15:0] stackPtr,
  input wire logic doneStrobe,
  input wire logic [5:0] loadMask,
  input wire logic [15:0] idxYOut
);
  timeunit 1ns;
  timeprecision 1ps;
  import csp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic take;
  logic [7:0] pcLow, pcHigh;
  csp_op_t lastOpReg, lastOpNext;
  // Plain views of the request for the history functions.
  assign take = cmdValid && cmdReady;
  assign pcLow = pcIn[7:0];
  assign pcHigh = pcIn[15:8];
  // ----------------------------------------------------------------
  // Last accepted command
  // ----------------------------------------------------------------
  // Vector reads are not stack reads, so the pull check needs the command.
  always_comb begin
    lastOpNext = take ? cmdOp : lastOpReg;
  end
  always_ff @(posedge ref_clk) begin
    lastOpReg <= lastOpNext;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  push_then_dec_a: assert property (memWrEn |-> stackPtr == memAddr - 16'h0001)
    else $error("Push without decrement.");
  pull_inc_first_a: assert property (memRdEn && lastOpReg != OP_INTERRUPT |-> memAddr == stackPtr)
    else $error("Pull not at new pointer.");
  ptr_inc_a: assert property (take && cmdOp == OP_PTR_INCREMENT |=>
    doneStrobe && stackPtr == $past(stackPtr) + 16'h0001) else $error("Increment wrong.");
  ptr_dec_a: assert property (take && cmdOp == OP_PTR_DECREMENT |=>
    doneStrobe && stackPtr == $past(stackPtr) - 16'h0001) else $error("Decrement wrong.");
  x_to_ptr_a: assert property (take && cmdOp == OP_INDEX_X_TO_PTR |=>
    stackPtr == $past(idxXIn) - 16'h0001) else $error("Index to pointer wrong.");
  ptr_to_y_a: assert property (take && cmdOp == OP_PTR_TO_INDEX_Y |=>
    loadMask[LD_Y] && idxYOut == $past(stackPtr) + 16'h0001) else $error("Pointer to Y wrong.");
  acc_push_byte_a: assert property (take && cmdOp == OP_PUSH_ACC_A |-> ##2
    (memWrEn && memWrData == $past(accAIn, 2)) ##[1:2] doneStrobe) else $error("Push A wrong.");
  call_byte_order_a: assert property (take && cmdOp == OP_SUBROUTINE_CALL |-> ##2
    (memWrEn && memWrData == $past(pcLow, 2)) ##1 (memWrEn && memWrData == $past(pcHigh, 3)))
    else $error("Call byte order wrong.");
  intr_vector_a: assert property (take && cmdOp == OP_INTERRUPT |-> ##[15:20]
    (doneStrobe && loadMask == 6'h01)) else $error("Interrupt end wrong.");
  cover property (take && cmdOp == OP_INTERRUPT);
  cover property (take && cmdOp == OP_RETURN_FROM_INTERRUPT);
  cover property (take && cmdOp == OP_PULL_INDEX_X);
endmodule

bind csp_stack_unit csp_stack_unit_monitor i_csp_stack_unit_monitor (.ref_clk(ref_clk),
  .srst(srst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady), .pcIn(pcIn),
  .idxXIn(idxXIn), .accAIn(accAIn), .memAddr(memAddr), .memWrData(memWrData),
  .memWrEn(memWrEn), .memRdEn(memRdEn), .stackPtr(stackPtr), .doneStrobe(doneStrobe),
  .loadMask(loadMask), .idxYOut(idxYOut));

// File: tb/tb_csp_stack_unit.sv
// Self-checking testbench of the stack unit.
module tb_csp_stack_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import csp_pkg::*;
  typedef struct {
    csp_op_t op;
    logic [15:0] val, expPtr;
    logic [5:0] expMask;
    logic [15:0] expRes;
  } csp_row_t;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cmdValid = 1'b0;
  csp_op_t cmdOp = OP_LOAD_PTR;
  logic [15:0] pcIn, idxXIn, idxYIn, ptrLoadIn, vectorAddrIn;
  logic [7:0] accAIn, accBIn, ccIn;
  logic cmdReady, memWrEn, memRdEn, doneStrobe;
  logic [15:0] memAddr, stackPtr, pcOut, idxXOut, idxYOut;
  logic [7:0] memWrData, memRdData, accAOut, accBOut, ccOut;
  logic [5:0] loadMask, gotMask;
  int nMismatch = 0, checkCount = 0;
  csp_row_t rows [16];
  // The clock has a 4 ns period.
  always #2 ref_clk = ~ref_clk;
  csp_stack_unit i_csp_stack_unit (.ref_clk(ref_clk), .srst(srst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdReady(cmdReady), .pcIn(pcIn), .idxXIn(idxXIn), .idxYIn(idxYIn),
    .accAIn(accAIn), .accBIn(accBIn), .ccIn(ccIn), .ptrLoadIn(ptrLoadIn),
    .vectorAddrIn(vectorAddrIn), .memAddr(memAddr), .memWrData(memWrData), .memWrEn(memWrEn),
    .memRdEn(memRdEn), .memRdData(memRdData), .stackPtr(stackPtr), .doneStrobe(doneStrobe),
    .loadMask(loadMask), .pcOut(pcOut), .idxXOut(idxXOut), .idxYOut(idxYOut),
    .accAOut(accAOut), .accBOut(accBOut), .ccOut(ccOut));
  csp_ram_model i_csp_ram_model (.ref_clk(ref_clk), .memAddr(memAddr), .memWrData(memWrData),
    .memWrEn(memWrEn), .memRdEn(memRdEn), .memRdData(memRdData));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mem(input logic [15:0] addr, input logic [7:0] exp);
    chk_val({8'h00, i_csp_ram_model.mem[addr]}, {8'h00, exp});
  endtask
  task automatic endSim();
    $display("Checks %0d, mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The X, Y, A or B result register that the mask names, else zero.
  function automatic logic [15:0] pick(input logic [5:0] m);
    if (m[LD_X]) return idxXOut;
    if (m[LD_Y]) return idxYOut;
    if (m[LD_A]) return {8'h00, accAOut};
    if (m[LD_B]) return {8'h00, accBOut};
    return 16'h0000;
  endfunction
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic set_all(input logic [15:0] v);
    @(posedge ref_clk);
    pcIn <= v;
    idxXIn <= v;
    idxYIn <= v;
    ptrLoadIn <= v;
    accAIn <= v[7:0];
    accBIn <= v[7:0];
    ccIn <= v[7:0];
    #1;
  endtask
  // Holds the request over its take edge, then waits a bounded time for done.
  task automatic run_cmd(input csp_op_t op);
    int n = 0;
    while (cmdReady !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdOp <= op;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    #1;
    n = 0;
    while (doneStrobe !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    gotMask = loadMask;
    chk_val({15'h0000, doneStrobe}, 16'h0001);
  endtask
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // The tests need under a thousand cycles; this fires only on a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    nMismatch++;
    endSim();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{OP_LOAD_PTR, 16'h037F, 16'h037F, 6'h00, 16'h0000},
      '{OP_PUSH_ACC_A, 16'h00A5, 16'h037E, 6'h00, 16'h0000},
      '{OP_PUSH_ACC_B, 16'h005A, 16'h037D, 6'h00, 16'h0000},
      '{OP_PUSH_INDEX_X, 16'h1234, 16'h037B, 6'h00, 16'h0000},
      '{OP_PUSH_INDEX_Y, 16'hABCD, 16'h0379, 6'h00, 16'h0000},
      '{OP_PULL_INDEX_X, 16'h0000, 16'h037B, 6'h02, 16'hABCD},
      '{OP_PULL_INDEX_Y, 16'h0000, 16'h037D, 6'h04, 16'h1234},
      '{OP_PULL_ACC_A, 16'h0000, 16'h037E, 6'h08, 16'h005A},
      '{OP_PULL_ACC_B, 16'h0000, 16'h037F, 6'h10, 16'h00A5},
      '{OP_PTR_DECREMENT, 16'h0000, 16'h037E, 6'h00, 16'h0000},
      '{OP_PTR_INCREMENT, 16'h0000, 16'h037F, 6'h00, 16'h0000},
      '{OP_INDEX_X_TO_PTR, 16'h0400, 16'h03FF, 6'h00, 16'h0000},
      '{OP_INDEX_Y_TO_PTR, 16'h0000, 16'hFFFF, 6'h00, 16'h0000},
      '{OP_PTR_TO_INDEX_X, 16'h0000, 16'hFFFF, 6'h02, 16'h0000},
      '{OP_INDEX_X_TO_PTR, 16'h0300, 16'h02FF, 6'h00, 16'h0000},
      '{OP_PTR_TO_INDEX_Y, 16'h0000, 16'h02FF, 6'h04, 16'h0300}};
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk_val({12'h000, cmdReady, memWrEn, memRdEn, doneStrobe}, 16'h0000);
    chk_val({10'h000, loadMask}, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk_val({15'h0000, cmdReady}, 16'h0001);
    foreach (rows[i]) begin
      set_all(rows[i].val);
      run_cmd(rows[i].op);
      chk_val(stackPtr, rows[i].expPtr);
      chk_val({10'h000, gotMask}, {10'h000, rows[i].expMask});
      chk_val(pick(gotMask), rows[i].expRes);
    end
    chk_mem(16'h037C, 8'h12);
    chk_mem(16'h037D, 8'h34);
    // A subroutine call, low byte first.
    set_all(16'h0200);
    run_cmd(OP_LOAD_PTR);
    set_all(16'hBEEF);
    run_cmd(OP_SUBROUTINE_CALL);
    chk_mem(16'h0200, 8'hEF);
    chk_mem(16'h01FF, 8'hBE);
    chk_val(stackPtr, 16'h01FE);
    // Interrupt stacking, a distinct byte per slot.
    i_csp_ram_model.mem[16'hFFF6] = 8'h56;
    i_csp_ram_model.mem[16'hFFF7] = 8'h78;
    @(posedge ref_clk);
    pcIn <= 16'hC1C2;
    idxYIn <= 16'hB1B2;
    idxXIn <= 16'hA1A2;
    accAIn <= 8'hD1;
    accBIn <= 8'hE1;
    ccIn <= 8'hF1;
    vectorAddrIn <= 16'hFFF6;
    #1;
    run_cmd(OP_INTERRUPT);
    for (int i = 0; i < 9; i++) begin
      chk_mem(16'h01FE - i[15:0], 8'(72'hC2C1B2B1A2A1D1E1F1 >> (8 * (8 - i))));
    end
    chk_val(stackPtr, 16'h01F5);
    chk_val(pcOut, 16'h5678);
    chk_val({10'h000, gotMask}, 16'h0001);
    // Return from interrupt with live inputs cleared, so only the stack restores.
    set_all(16'h0000);
    run_cmd(OP_RETURN_FROM_INTERRUPT);
    chk_val({10'h000, gotMask}, 16'h003F);
    chk_val(pcOut, 16'hC1C2);
    chk_val(idxYOut, 16'hB1B2);
    chk_val(idxXOut, 16'hA1A2);
    chk_val({accAOut, accBOut}, 16'hD1E1);
    chk_val({8'h00, ccOut}, 16'h00F1);
    chk_val(stackPtr, 16'h01FE);
    // Two increments back to back, then a reset that spares the pointer.
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdOp <= OP_PTR_INCREMENT;
    repeat (2) @(posedge ref_clk);
    cmdValid <= 1'b0;
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    chk_val(stackPtr, 16'h0200);
    chk_val(pcOut, 16'h0000);
    endSim();
  end
endmodule

// File: verilog/csp_pkg.sv
// Constants, slots, command codes and states of the stack pointer unit.
// Function
// - Stack pointer is 16 bits wide and reaches the whole 64 K byte space.
// - Stack pointer has no reset value; software loads it before use.
// - Each pushed byte goes to the pointer address, then the pointer decrements.
// - A subroutine call pushes the return address low byte first.
// - The call's second push puts the return high byte one address lower.
// - An unmasked interrupt stacks every register except the stack pointer.
// - After interrupt stacking the vector is fetched and execution resumes there.
// - Return from interrupt pulls every saved register in exact reverse order.
// - Accumulators A and B can each be pushed and pulled as one byte.
// - Index registers X and Y can each be pushed and pulled as two bytes.
// - Separate commands add one to and subtract one from the pointer.
// - Moving X or Y to the pointer loads the index value minus one.
// - Moving the pointer to X or Y loads the pointer value plus one.
package csp_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed adjustments
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int FRAME_BYTES = 9;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [15:0] VECTOR_STEP = 16'h0001;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Frame slots, numbered in interrupt stacking order
  // ----------------------------------------------------------------
  localparam logic [3:0] SLOT_PCL = 4'h0;
  localparam logic [3:0] SLOT_PCH = 4'h1;
  localparam logic [3:0] SLOT_YL = 4'h2;
  localparam logic [3:0] SLOT_YH = 4'h3;
  localparam logic [3:0] SLOT_XL = 4'h4;
  localparam logic [3:0] SLOT_XH = 4'h5;
  localparam logic [3:0] SLOT_A = 4'h6;
  localparam logic [3:0] SLOT_B = 4'h7;
  localparam logic [3:0] SLOT_CCR = 4'h8;

  // ----------------------------------------------------------------
  // Sequence lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_FRAME = 4'h9;

  // ----------------------------------------------------------------
  // Bits of the register load mask
  // ----------------------------------------------------------------
  localparam int LD_PC = 0;
  localparam int LD_X = 1;
  localparam int LD_Y = 2;
  localparam int LD_A = 3;
  localparam int LD_B = 4;
  localparam int LD_CC = 5;
  localparam logic [5:0] MASK_NONE = 6'h00;
  localparam logic [5:0] MASK_ALL = 6'h3F;

  // ----------------------------------------------------------------
  // Commands, pointer operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_PUSH_ACC_A = 5'h00,
    OP_PUSH_ACC_B = 5'h01,
    OP_PULL_ACC_A = 5'h02,
    OP_PULL_ACC_B = 5'h03,
    OP_PUSH_INDEX_X = 5'h04,
    OP_PUSH_INDEX_Y = 5'h05,
    OP_PULL_INDEX_X = 5'h06,
    OP_PULL_INDEX_Y = 5'h07,
    OP_PTR_INCREMENT = 5'h08,
    OP_PTR_DECREMENT = 5'h09,
    OP_INDEX_X_TO_PTR = 5'h0A,
    OP_INDEX_Y_TO_PTR = 5'h0B,
    OP_PTR_TO_INDEX_X = 5'h0C,
    OP_PTR_TO_INDEX_Y = 5'h0D,
    OP_SUBROUTINE_CALL = 5'h0E,
    OP_INTERRUPT = 5'h0F,
    OP_RETURN_FROM_INTERRUPT = 5'h10,
    OP_LOAD_PTR = 5'h11
  } csp_op_t;

  typedef enum logic [1:0] {
    PTR_HOLD = 2'h0,
    PTR_INC = 2'h1,
    PTR_DEC = 2'h2,
    PTR_LOAD = 2'h3
  } csp_ptr_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_PULL = 3'h2,
    ST_VECTOR = 3'h3,
    ST_RD_WAIT = 3'h4,
    ST_RD_CAPTURE = 3'h5,
    ST_FINISH = 3'h6
  } csp_state_t;

endpackage

// File: verilog/csp_stack_ptr.sv
// Stack pointer register with increment, decrement and load.
module csp_stack_ptr #(
  parameter int PTR_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire csp_pkg::csp_ptr_op_t ptrOp,
  input wire logic [15:0] ptrLoad,
  output logic [15:0] stackPtr
);
  import csp_pkg::*;

  logic [15:0] stackPtr_reg;
  logic [15:0] stackPtr_next;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The sequencer drives a 16-bit bus, so only that width is served.
  if (PTR_WIDTH != ADDR_W) begin : g_width_check
    $error("csp_stack_ptr supports only a 16-bit pointer");
  end

  // ----------------------------------------------------------------
  // Pointer arithmetic
  // ----------------------------------------------------------------
  // Wraps modulo 64 K, so the stack may sit anywhere in memory.
  always_comb begin
    case (ptrOp)
      PTR_INC: stackPtr_next = stackPtr_reg + PTR_STEP;
      PTR_DEC: stackPtr_next = stackPtr_reg - PTR_STEP;
      PTR_LOAD: stackPtr_next = ptrLoad;
      PTR_HOLD: stackPtr_next = stackPtr_reg;
      default: stackPtr_next = stackPtr_reg;
    endcase
  end

  // Deliberately no reset: the pointer is undefined until software loads it.
  always_ff @(posedge ref_clk) begin
    stackPtr_reg <= stackPtr_next;
  end

  assign stackPtr = stackPtr_reg;

endmodule

// File: verilog/csp_stack_unit.sv
// Stack sequencer: pushes, pulls, calls, interrupts and transfers.
module csp_stack_unit #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmdValid,
  input wire csp_pkg::csp_op_t cmdOp,
  output logic cmdReady,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] idxXIn,
  input wire logic [15:0] idxYIn,
  input wire logic [7:0] accAIn,
  input wire logic [7:0] accBIn,
  input wire logic [7:0] ccIn,
  input wire logic [15:0] ptrLoadIn,
  input wire logic [15:0] vectorAddrIn,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrEn,
  output logic memRdEn,
  input wire logic [7:0] memRdData,
  output logic [15:0] stackPtr,
  output logic doneStrobe,
  output logic [5:0] loadMask,
  output logic [15:0] pcOut,
  output logic [15:0] idxXOut,
  output logic [15:0] idxYOut,
  output logic [7:0] accAOut,
  output logic [7:0] accBOut,
  output logic [7:0] ccOut
);
  import csp_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_WIDTH != ADDR_W) begin : g_width_check
    $error("csp_stack_unit supports only a 16-bit address space");
  end

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  // Number of bytes moved by a memory-touching command.
  function automatic logic [3:0] opLength(input csp_op_t op);
    case (op)
      OP_PUSH_ACC_A, OP_PUSH_ACC_B, OP_PULL_ACC_A, OP_PULL_ACC_B: opLength = LEN_ONE;
      OP_PUSH_INDEX_X, OP_PUSH_INDEX_Y, OP_PULL_INDEX_X, OP_PULL_INDEX_Y,
      OP_SUBROUTINE_CALL: opLength = LEN_TWO;
      OP_INTERRUPT, OP_RETURN_FROM_INTERRUPT: opLength = LEN_FRAME;
      default: opLength = LEN_ONE;
    endcase
  endfunction

  // Frame slot written to memory at push step idx; low bytes go first.
  function automatic logic [3:0] pushSlot(input csp_op_t op, input logic [3:0] idx);
    case (op)
      OP_PUSH_ACC_A: pushSlot = SLOT_A;
      OP_PUSH_ACC_B: pushSlot = SLOT_B;
      OP_PUSH_INDEX_X: pushSlot = (idx == 4'h0) ? SLOT_XL : SLOT_XH;
      OP_PUSH_INDEX_Y: pushSlot = (idx == 4'h0) ? SLOT_YL : SLOT_YH;
      OP_SUBROUTINE_CALL: pushSlot = (idx == 4'h0) ? SLOT_PCL : SLOT_PCH;
      OP_INTERRUPT: pushSlot = idx;
      default: pushSlot = SLOT_A;
    endcase
  endfunction

  // Frame slot filled at pull step idx; always the mirror of the push order.
  function automatic logic [3:0] pullSlot(input csp_op_t op, input logic [3:0] idx);
    case (op)
      OP_PULL_ACC_A: pullSlot = SLOT_A;
      OP_PULL_ACC_B: pullSlot = SLOT_B;
      OP_PULL_INDEX_X: pullSlot = (idx == 4'h0) ? SLOT_XH : SLOT_XL;
      OP_PULL_INDEX_Y: pullSlot = (idx == 4'h0) ? SLOT_YH : SLOT_YL;
      OP_RETURN_FROM_INTERRUPT: pullSlot = SLOT_CCR - idx;
      default: pullSlot = SLOT_A;
    endcase
  endfunction

  // Registers handed back to the core when the command completes.
  function automatic logic [5:0] opMask(input csp_op_t op);
    opMask = MASK_NONE;
    case (op)
      OP_PULL_ACC_A: opMask[LD_A] = 1'b1;
      OP_PULL_ACC_B: opMask[LD_B] = 1'b1;
      OP_PULL_INDEX_X, OP_PTR_TO_INDEX_X: opMask[LD_X] = 1'b1;
      OP_PULL_INDEX_Y, OP_PTR_TO_INDEX_Y: opMask[LD_Y] = 1'b1;
      OP_INTERRUPT: opMask[LD_PC] = 1'b1;
      OP_RETURN_FROM_INTERRUPT: opMask = MASK_ALL;
      default: opMask = MASK_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csp_state_t state_reg, state_next;
  csp_op_t op_reg, op_next;
  logic [3:0] idx_reg, idx_next;
  logic [3:0] len_reg, len_next;
  logic vecLow_reg, vecLow_next;
  logic [15:0] vecAddr_reg, vecAddr_next;
  logic [7:0] frame_reg [FRAME_BYTES];
  logic [7:0] frame_next [FRAME_BYTES];
  logic [15:0] memAddr_reg, memAddr_next;
  logic [7:0] memWrData_reg, memWrData_next;
  logic memWrEn_reg, memWrEn_next;
  logic memRdEn_reg, memRdEn_next;
  logic cmdReady_reg, cmdReady_next;
  logic done_reg, done_next;
  logic [5:0] loadMask_reg, loadMask_next;
  csp_ptr_op_t ptrOp;
  logic [15:0] ptrLoad;
  logic [15:0] ptrPlusOne;
  logic cmdTaken;

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  csp_stack_ptr #(
    .PTR_WIDTH(ADDR_WIDTH)
  ) u_stack_ptr (
    .ref_clk(ref_clk),
    .ptrOp(ptrOp),
    .ptrLoad(ptrLoad),
    .stackPtr(stackPtr)
  );

  assign ptrPlusOne = stackPtr + PTR_STEP;
  assign cmdTaken = cmdValid && cmdReady_reg;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  // One byte moves per bus cycle; reads return data the cycle after memRdEn.
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    len_next = len_reg;
    vecLow_next = vecLow_reg;
    vecAddr_next = vecAddr_reg;
    frame_next = frame_reg;
    memAddr_next = memAddr_reg;
    memWrData_next = memWrData_reg;
    memWrEn_next = 1'b0;
    memRdEn_next = 1'b0;
    cmdReady_next = cmdReady_reg;
    done_next = 1'b0;
    loadMask_next = MASK_NONE;
    ptrOp = PTR_HOLD;
    ptrLoad = stackPtr;
    case (state_reg)
      ST_IDLE: begin
        cmdReady_next = 1'b1;
        if (cmdTaken) begin
          // Snapshot the whole register set so a push never sees a moving source.
          frame_next[SLOT_PCL] = pcIn[7:0];
          frame_next[SLOT_PCH] = pcIn[15:8];
          frame_next[SLOT_YL] = idxYIn[7:0];
          frame_next[SLOT_YH] = idxYIn[15:8];
          frame_next[SLOT_XL] = idxXIn[7:0];
          frame_next[SLOT_XH] = idxXIn[15:8];
          frame_next[SLOT_A] = accAIn;
          frame_next[SLOT_B] = accBIn;
          frame_next[SLOT_CCR] = ccIn;
          op_next = cmdOp;
          idx_next = 4'h0;
          len_next = opLength(cmdOp);
          vecLow_next = 1'b0;
          vecAddr_next = vectorAddrIn;
          case (cmdOp)
            OP_PTR_INCREMENT: begin
              ptrOp = PTR_INC;
              done_next = 1'b1;
            end
            OP_PTR_DECREMENT: begin
              ptrOp = PTR_DEC;
              done_next = 1'b1;
            end
            OP_INDEX_X_TO_PTR: begin
              ptrOp = PTR_LOAD;
              ptrLoad = idxXIn - PTR_STEP;
              done_next = 1'b1;
            end
            OP_INDEX_Y_TO_PTR: begin
              ptrOp = PTR_LOAD;
              ptrLoad = idxYIn - PTR_STEP;
              done_next = 1'b1;
            end
            OP_LOAD_PTR: begin
              ptrOp = PTR_LOAD;
              ptrLoad = ptrLoadIn;
              done_next = 1'b1;
            end
            OP_PTR_TO_INDEX_X: begin
              frame_next[SLOT_XL] = ptrPlusOne[7:0];
              frame_next[SLOT_XH] = ptrPlusOne[15:8];
              done_next = 1'b1;
              loadMask_next = opMask(cmdOp);
            end
            OP_PTR_TO_INDEX_Y: begin
              frame_next[SLOT_YL] = ptrPlusOne[7:0];
              frame_next[SLOT_YH] = ptrPlusOne[15:8];
              done_next = 1'b1;
              loadMask_next = opMask(cmdOp);
            end
            OP_PUSH_ACC_A, OP_PUSH_ACC_B, OP_PUSH_INDEX_X, OP_PUSH_INDEX_Y,
            OP_SUBROUTINE_CALL, OP_INTERRUPT: begin
              state_next = ST_PUSH;
              cmdReady_next = 1'b0;
            end
            OP_PULL_ACC_A, OP_PULL_ACC_B, OP_PULL_INDEX_X, OP_PULL_INDEX_Y,
            OP_RETURN_FROM_INTERRUPT: begin
              state_next = ST_PULL;
              cmdReady_next = 1'b0;
            end
            default: begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      ST_PUSH: begin
        // Write at the current pointer, then step it down to the next free byte.
        memAddr_next = stackPtr;
        memWrData_next = frame_reg[pushSlot(op_reg, idx_reg)];
        memWrEn_next = 1'b1;
        ptrOp = PTR_DEC;
        idx_next = idx_reg + 4'h1;
        if (idx_reg == len_reg - 4'h1) begin
          state_next = (op_reg == OP_INTERRUPT) ? ST_VECTOR : ST_FINISH;
        end
      end
      ST_PULL: begin
        // Step the pointer up first and read from the address it now holds.
        ptrOp = PTR_INC;
        memAddr_next = ptrPlusOne;
        memRdEn_next = 1'b1;
        state_next = ST_RD_WAIT;
      end
      ST_VECTOR: begin
        // Vector is stored high byte first, like every 16-bit word in memory.
        memAddr_next = vecLow_reg ? (vecAddr_reg + VECTOR_STEP) : vecAddr_reg;
        memRdEn_next = 1'b1;
        state_next = ST_RD_WAIT;
      end
      ST_RD_WAIT: begin
        state_next = ST_RD_CAPTURE;
      end
      ST_RD_CAPTURE: begin
        if (op_reg == OP_INTERRUPT) begin
          frame_next[vecLow_reg ? SLOT_PCL : SLOT_PCH] = memRdData;
          vecLow_next = 1'b1;
          state_next = vecLow_reg ? ST_FINISH : ST_VECTOR;
        end else begin
          frame_next[pullSlot(op_reg, idx_reg)] = memRdData;
          idx_next = idx_reg + 4'h1;
          state_next = (idx_reg == len_reg - 4'h1) ? ST_FINISH : ST_PULL;
        end
      end
      ST_FINISH: begin
        done_next = 1'b1;
        loadMask_next = opMask(op_reg);
        cmdReady_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
        cmdReady_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  // The frame is reset too, so result outputs are defined from reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_PUSH_ACC_A;
      idx_reg <= 4'h0;
      len_reg <= LEN_ONE;
      vecLow_reg <= 1'b0;
      vecAddr_reg <= ADDR_RST;
      for (int i = 0; i < FRAME_BYTES; i++) begin
        frame_reg[i] <= BYTE_RST;
      end
      memAddr_reg <= ADDR_RST;
      memWrData_reg <= BYTE_RST;
      memWrEn_reg <= 1'b0;
      memRdEn_reg <= 1'b0;
      cmdReady_reg <= 1'b0;
      done_reg <= 1'b0;
      loadMask_reg <= MASK_NONE;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      len_reg <= len_next;
      vecLow_reg <= vecLow_next;
      vecAddr_reg <= vecAddr_next;
      frame_reg <= frame_next;
      memAddr_reg <= memAddr_next;
      memWrData_reg <= memWrData_next;
      memWrEn_reg <= memWrEn_next;
      memRdEn_reg <= memRdEn_next;
      cmdReady_reg <= cmdReady_next;
      done_reg <= done_next;
      loadMask_reg <= loadMask_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All outputs are flip-flops; 16-bit results join two frame bytes.
  assign cmdReady = cmdReady_reg;
  assign memAddr = memAddr_reg;
  assign memWrData = memWrData_reg;
  assign memWrEn = memWrEn_reg;
  assign memRdEn = memRdEn_reg;
  assign doneStrobe = done_reg;
  assign loadMask = loadMask_reg;
  assign pcOut = {frame_reg[SLOT_PCH], frame_reg[SLOT_PCL]};
  assign idxXOut = {frame_reg[SLOT_XH], frame_reg[SLOT_XL]};
  assign idxYOut = {frame_reg[SLOT_YH], frame_reg[SLOT_YL]};
  assign accAOut = frame_reg[SLOT_A];
  assign accBOut = frame_reg[SLOT_B];
  assign ccOut = frame_reg[SLOT_CCR];

endmodule
